// ===== src/cb_status_map.svh
// Offsets, field positions, codes and reset values of the status block.
// Assumes inclusion by bare name from the design modules and the checker.
`ifndef CB_STATUS_MAP_SVH
`define CB_STATUS_MAP_SVH

// Interrupt code field of the interrupt code status register
`define CODE_LSB 6
`define CODE_MSB 15

// Asynchronous interrupt codes; host reads them as octal 0..16
`define CODE_NULL 10'h000
`define CODE_SOFT 10'h002
`define CODE_HARD 10'h003
`define CODE_IBIT 10'h004
`define CODE_DONE 10'h005
`define CODE_SBIT 10'h007
`define CODE_STATNZ 10'h008
`define CODE_ILLCMD 10'h009
`define CODE_PAGE 10'h00b
`define CODE_XFER 10'h00e

// Error status word bit positions
`define ERR_ENDADDR_BIT 7
`define ERR_CHAN_BIT 12

// Return word indices inside a control block
`define WORD_STATUS 4'hb
`define WORD_ERROR 4'he
`define WORD_UNIT 4'hf

// Control block command codes
`define CMD_READ 4'h0
`define CMD_WRITE 4'h1
`define CMD_RD_VERIFY 4'h2
`define CMD_RD_RAW 4'h3
`define CMD_RD_HEADERS 4'h4
`define CMD_WR_VERIFY 4'h5
`define CMD_WR_VER_WORD 4'h6

// Reset values
`define REG_RESET 16'h0000

`endif

// ===== src/cb_status_pkg.sv
// Types shared by the status reporting block and its command mapper.
// Assumes nothing beyond a SystemVerilog compiler.
package cb_status_pkg;
	// What execution does with a control block command
	typedef enum logic [1:0] {
		ACT_EXEC,
		ACT_NOOP,
		ACT_WRITE,
		ACT_ILLEGAL
	} action_t;

	// Return word write-back sequencer states
	typedef enum logic [1:0] {
		WB_IDLE,
		WB_STATUS,
		WB_ERROR,
		WB_UNIT
	} wb_state_t;
endpackage

// ===== src/cb_command_map.sv
// Combinational mapping of a control block command to its execution.
// Assumes the caller registers the result.
`include "cb_status_map.svh"

module cb_command_map (
	input wire logic [3:0] cmd,
	output cb_status_pkg::action_t action
);
	// Redefined commands; all others execute as given
	always_comb begin
		case (cmd)
			`CMD_RD_VERIFY: action = cb_status_pkg::ACT_NOOP;
			`CMD_WR_VER_WORD: action = cb_status_pkg::ACT_NOOP;
			`CMD_RD_RAW: action = cb_status_pkg::ACT_ILLEGAL;
			`CMD_RD_HEADERS: action = cb_status_pkg::ACT_ILLEGAL;
			`CMD_WR_VERIFY: action = cb_status_pkg::ACT_WRITE;
			`CMD_WRITE: action = cb_status_pkg::ACT_WRITE;
			default: action = cb_status_pkg::ACT_EXEC;
		endcase
	end
endmodule

// ===== src/cb_status_report.sv
// Status and interrupt reporting of a control block storage controller.
// Assumes all inputs synchronous to clk and event inputs one-cycle pulses.
`include "cb_status_map.svh"

module cb_status_report (
	input wire logic clk,
	input wire logic rst_n,
	// Control block accepted for execution
	input wire logic cbStart,
	input wire logic [3:0] cbCmd,
	input wire logic listStart,
	// Control block execution outcome
	input wire logic cbFinish,
	input wire logic cbSoftErr,
	input wire logic cbHardErr,
	input wire logic cbSuspend,
	input wire logic cbIntOnDone,
	input wire logic listDone,
	// Interpretation failures, each ending the block
	input wire logic interpStatusNz,
	input wire logic interpBadPage,
	input wire logic interpBadXfer,
	// Return words gathered during execution
	input wire logic [15:0] cbStatusWord,
	input wire logic [15:0] cbErrorWord,
	input wire logic [15:0] cbUnitWord,
	// Programmed I/O command completion
	input wire logic pioDone,
	input wire logic pioErrCapable,
	input wire logic pioFail,
	input wire logic pioErrEndAddr,
	input wire logic pioErrChannel,
	input wire logic [15:0] pioReturnC,
	input wire logic syncIntEnable,
	// Host acknowledges the interrupt it sees
	input wire logic intAck,
	// Command mapping result
	output cb_status_pkg::action_t cbAction_q,
	output logic cbActionValid_q,
	// Status registers and state
	output logic [15:0] errorStatusWord_q,
	output logic [15:0] interruptCodeStatus_q,
	output logic execBusy_q,
	output logic listStarted_q,
	output logic cmdComplete_q,
	// Interrupt lines
	output logic syncIrq_q,
	output logic asyncIrq_q,
	// Return word write-back to the control block
	output logic wbValid_q,
	output logic [3:0] wbWord_q,
	output logic [15:0] wbData_q
);
	cb_status_pkg::action_t mapAction; // Mapper output
	cb_status_pkg::wb_state_t wbState_q; // Write-back state
	logic [15:0] errWord_q; // Captured error word
	logic [15:0] unitWord_q; // Captured unit word
	logic [15:0] statWord_q; // Captured status word
	logic illegalSeen_q; // Current block mapped illegal
	logic syncPend_q; // Synchronous interrupt pending
	logic asyncPend_q; // Asynchronous interrupt pending
	logic asyncEvent; // Any asynchronous cause this cycle
	logic interpEvent; // Interpretation error this cycle
	logic [9:0] asyncCode; // Code for this cycle's cause
	logic syncEvent; // Synchronous interrupt cause
	logic ackSync; // Host clears sync interrupt
	logic ackAsync; // Host clears async interrupt

	// Redefined command translation
	cb_command_map uMap (
		.cmd(cbCmd),
		.action(mapAction)
	);

	// Register the mapping for the execution engine
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cbAction_q <= cb_status_pkg::ACT_EXEC;
			cbActionValid_q <= 1'b0;
			illegalSeen_q <= 1'b0;
		end else begin
			cbActionValid_q <= cbStart;
			if (cbStart) begin
				cbAction_q <= mapAction;
				illegalSeen_q <= (mapAction == cb_status_pkg::ACT_ILLEGAL);
			end else if (cbActionValid_q && illegalSeen_q) begin
				illegalSeen_q <= 1'b0;
			end
		end
	end

	// Cause decoding, errors ahead of clean completion
	always_comb begin
		interpEvent = interpStatusNz | interpBadPage | interpBadXfer;
		asyncEvent = cbFinish | listDone | interpEvent |
			(cbActionValid_q & illegalSeen_q);
		if (interpStatusNz) begin
			asyncCode = `CODE_STATNZ;
		end else if (cbActionValid_q && illegalSeen_q) begin
			asyncCode = `CODE_ILLCMD;
		end else if (interpBadPage) begin
			asyncCode = `CODE_PAGE;
		end else if (interpBadXfer) begin
			asyncCode = `CODE_XFER;
		end else if (cbFinish && cbHardErr) begin
			asyncCode = `CODE_HARD;
		end else if (cbFinish && cbSoftErr && cbSuspend) begin
			asyncCode = `CODE_SBIT;
		end else if (cbFinish && cbSoftErr) begin
			asyncCode = `CODE_SOFT;
		end else if (cbFinish && cbIntOnDone) begin
			asyncCode = `CODE_IBIT;
		end else if (cbFinish || listDone) begin
			asyncCode = `CODE_DONE;
		end else begin
			asyncCode = `CODE_NULL;
		end
	end

	// Sync cause and acknowledge steering
	always_comb begin
		syncEvent = pioDone & syncIntEnable;
		ackSync = intAck & syncPend_q;
		ackAsync = intAck & ~syncPend_q & asyncPend_q;
	end

	// Pending flags; a new cause wins over an acknowledge
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			syncPend_q <= 1'b0;
			asyncPend_q <= 1'b0;
		end else begin
			if (syncEvent) begin
				syncPend_q <= 1'b1;
			end else if (ackSync) begin
				syncPend_q <= 1'b0;
			end
			if (asyncEvent) begin
				asyncPend_q <= 1'b1;
			end else if (ackAsync) begin
				asyncPend_q <= 1'b0;
			end
		end
	end

	// Interrupt lines, sync masking async
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			syncIrq_q <= 1'b0;
			asyncIrq_q <= 1'b0;
		end else begin
			syncIrq_q <= syncPend_q & ~ackSync;
			asyncIrq_q <= asyncPend_q & ~syncPend_q & ~ackAsync;
		end
	end

	// Interrupt code register C
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			interruptCodeStatus_q <= `REG_RESET;
		end else if (syncEvent) begin
			interruptCodeStatus_q <= pioReturnC;
		end else if (asyncEvent && !syncPend_q) begin
			// Code field only; low bits read zero
			interruptCodeStatus_q <= {asyncCode, 6'h00};
		end
	end

	// Error status register B, loaded only on command failure
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			errorStatusWord_q <= `REG_RESET;
		end else if (pioDone && pioFail && pioErrCapable) begin
			errorStatusWord_q <= `REG_RESET;
			errorStatusWord_q[`ERR_ENDADDR_BIT] <= pioErrEndAddr;
			errorStatusWord_q[`ERR_CHAN_BIT] <= pioErrChannel;
		end
	end

	// Execution state, list start and completion status
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			execBusy_q <= 1'b0;
			listStarted_q <= 1'b0;
			cmdComplete_q <= 1'b0;
		end else begin
			if (cbStart) begin
				execBusy_q <= 1'b1;
				cmdComplete_q <= 1'b0;
			end else if (asyncEvent) begin
				execBusy_q <= 1'b0;
				cmdComplete_q <= 1'b1;
			end
			if (listStart) begin
				listStarted_q <= 1'b1;
			end else if (listDone || interpEvent) begin
				listStarted_q <= 1'b0;
			end
		end
	end

	// Capture return words at block end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			statWord_q <= `REG_RESET;
			errWord_q <= `REG_RESET;
			unitWord_q <= `REG_RESET;
		end else if (cbFinish && wbState_q == cb_status_pkg::WB_IDLE) begin
			statWord_q <= cbStatusWord;
			errWord_q <= cbErrorWord;
			unitWord_q <= cbUnitWord;
		end
	end

	// Three-word write-back sequencer
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wbState_q <= cb_status_pkg::WB_IDLE;
		end else begin
			case (wbState_q)
				cb_status_pkg::WB_IDLE: begin
					if (cbFinish) begin
						wbState_q <= cb_status_pkg::WB_STATUS;
					end
				end
				cb_status_pkg::WB_STATUS: wbState_q <= cb_status_pkg::WB_ERROR;
				cb_status_pkg::WB_ERROR: wbState_q <= cb_status_pkg::WB_UNIT;
				cb_status_pkg::WB_UNIT: wbState_q <= cb_status_pkg::WB_IDLE;
				default: wbState_q <= cb_status_pkg::WB_IDLE;
			endcase
		end
	end

	// Write-back outputs, registered from the state
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wbValid_q <= 1'b0;
			wbWord_q <= 4'h0;
			wbData_q <= `REG_RESET;
		end else begin
			case (wbState_q)
				cb_status_pkg::WB_STATUS: begin
					wbValid_q <= 1'b1;
					wbWord_q <= `WORD_STATUS;
					wbData_q <= statWord_q;
				end
				cb_status_pkg::WB_ERROR: begin
					wbValid_q <= 1'b1;
					wbWord_q <= `WORD_ERROR;
					wbData_q <= errWord_q;
				end
				cb_status_pkg::WB_UNIT: begin
					wbValid_q <= 1'b1;
					wbWord_q <= `WORD_UNIT;
					wbData_q <= unitWord_q;
				end
				default: begin
					wbValid_q <= 1'b0;
					wbWord_q <= 4'h0;
					wbData_q <= `REG_RESET;
				end
			endcase
		end
	end
endmodule

// ===== dv/host_ack_model.sv
// Host side model that acknowledges the interrupt line it sees.
// Assumes the interrupt lines are registered outputs of the block.
module host_ack_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic syncIrq,
	input wire logic asyncIrq,
	output logic intAck = 1'b0
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] lastKey = 2'h0; // Lines seen at the last edge
	logic [3:0] waitCnt = 4'h0; // Edges the lines have stood unchanged
	// One ack per change of the lines while either line is raised, after a short or a long wait
	always_ff @(posedge clk) begin
		lastKey <= {syncIrq, asyncIrq};
		if (!rst_n || lastKey != {syncIrq, asyncIrq}) begin
			waitCnt <= 4'h0;
		end else if (waitCnt != 4'hf) begin
			waitCnt <= waitCnt + 4'h1;
		end
		intAck <= rst_n && lastKey == {syncIrq, asyncIrq} &&
			lastKey != 2'h0 && waitCnt == (slow ? 4'h6 : 4'h1);
	end
endmodule

// ===== dv/cb_status_checker.sv
// Concurrent checks on the ports of the status reporting block.
// Assumes binding into cb_status_report; one clock, sync reset.
`include "cb_status_map.svh"

module cb_status_checker (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cbStart,
	input wire logic [3:0] cbCmd,
	input wire logic pioDone,
	input wire logic pioFail,
	input wire logic pioErrCapable,
	input wire logic pioErrEndAddr,
	input wire logic pioErrChannel,
	input wire logic [15:0] pioReturnC,
	input wire logic syncIntEnable,
	input wire logic intAck,
	input cb_status_pkg::action_t cbAction_q,
	input wire logic cbActionValid_q,
	input wire logic [15:0] errorStatusWord_q,
	input wire logic [15:0] interruptCodeStatus_q,
	input wire logic execBusy_q,
	input wire logic syncIrq_q,
	input wire logic asyncIrq_q,
	input wire logic wbValid_q,
	input wire logic [3:0] wbWord_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Sync request that is not acked away at once
	sequence syncReq;
		pioDone && syncIntEnable ##1 !intAck;
	endsequence
	// Last two return words of a write-back
	sequence wbTail;
		wbValid_q && wbWord_q == `WORD_ERROR ##1
		wbValid_q && wbWord_q == `WORD_UNIT ##1 !wbValid_q;
	endsequence
	AST_ACT_VALID: assert property (cbStart |=> cbActionValid_q)
		else $error("action valid missing");
	AST_RAW_ILLEGAL: assert property (cbStart && cbCmd == `CMD_RD_RAW |=>
		cbAction_q == cb_status_pkg::ACT_ILLEGAL) else $error("raw not illegal");
	AST_SYNC_RISE: assert property (syncReq |=> syncIrq_q)
		else $error("sync irq missing");
	AST_SYNC_FIRST: assert property (syncIrq_q |-> !asyncIrq_q)
		else $error("async shown over sync");
	AST_SYNC_C: assert property (pioDone && syncIntEnable |=>
		interruptCodeStatus_q == $past(pioReturnC)) else $error("sync C lost");
	AST_B_LOAD: assert property (pioDone && pioFail && pioErrCapable |=>
		errorStatusWord_q == {3'h0, $past(pioErrChannel), 4'h0,
		$past(pioErrEndAddr), 7'h00}) else $error("B word wrong");
	AST_B_HOLD: assert property (!(pioDone && pioFail && pioErrCapable)
		|=> $stable(errorStatusWord_q)) else $error("B changed");
	AST_B_ZERO: assert property ((errorStatusWord_q & 16'hef7f) == 16'h0000)
		else $error("B unused bit set");
	AST_WB_SEQ: assert property ($rose(wbValid_q) |->
		wbWord_q == `WORD_STATUS ##1 wbTail) else $error("write-back order");
	AST_BUSY: assert property (cbStart |=> execBusy_q)
		else $error("busy not set");
endmodule

bind cb_status_report cb_status_checker chk (.*);

// ===== dv/testbench.sv
// Self-checking bench for the status reporting block.
// Assumes the host model acks interrupts and the checker is bound.
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = '0, rst_n = '0, slow = '0, intAck;
	logic cbStart = '0, listStart = '0, cbFinish = '0, cbSoftErr = '0;
	logic cbHardErr = '0, cbSuspend = '0, cbIntOnDone = '0, listDone = '0;
	logic interpStatusNz = '0, interpBadPage = '0, interpBadXfer = '0;
	logic pioDone = '0, pioErrCapable = '0, pioFail = '0;
	logic pioErrEndAddr = '0, pioErrChannel = '0, syncIntEnable = '0;
	logic [3:0] cbCmd = '0, wbWord_q;
	logic [15:0] cbStatusWord = '0, cbErrorWord = '0, cbUnitWord = '0;
	logic [15:0] pioReturnC = '0, expB = '0;
	cb_status_pkg::action_t cbAction_q;
	logic cbActionValid_q, execBusy_q, listStarted_q, cmdComplete_q;
	logic syncIrq_q, asyncIrq_q, wbValid_q;
	logic [15:0] errorStatusWord_q, interruptCodeStatus_q, wbData_q;
	int error_cnt = 0, samples_checked = 0, cycles = 0;
	int codes[8] = '{2, 3, 7, 4, 5, 8, 11, 14}; // Octal codes as integers
	logic [15:0] words[$]; // Return words of the current block

	cb_status_report uut (.*);
	host_ack_model host (.clk(clk), .rst_n(rst_n), .slow(slow),
		.syncIrq(syncIrq_q), .asyncIrq(asyncIrq_q), .intAck(intAck));

	// 40 MHz clock
	always #12.5 clk = ~clk;
	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			error_cnt++;
			stop_test();
		end
	end
	// Compare one value
	task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Move to just after a later edge
	task automatic tick(int n = 1);
		repeat (n) @(posedge clk);
		#2;
	endtask
	// Verdict and end of run
	task automatic stop_test();
		$display("Checked %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// Reference mapping of command codes
	function automatic cb_status_pkg::action_t exp_act(int c);
		case (c)
			2, 6: return cb_status_pkg::ACT_NOOP;
			3, 4: return cb_status_pkg::ACT_ILLEGAL;
			1, 5: return cb_status_pkg::ACT_WRITE;
			default: return cb_status_pkg::ACT_EXEC;
		endcase
	endfunction

	initial begin
		void'($urandom(32'h76b0));
		tick(20);
		rst_n = 1'h1;
		// Every command code through the mapper
		for (int i = 0; i < 16; i++) begin
			cbCmd = 4'(i);
			cbStart = 1'h1;
			tick();
			cbStart = 1'h0;
			chk("valid", 16'(cbActionValid_q), 16'h0001);
			chk("action", 16'(cbAction_q), 16'(exp_act(i)));
			chk("busy", 16'(execBusy_q), 16'h0001);
			tick();
			if (exp_act(i) == cb_status_pkg::ACT_ILLEGAL)
				chk("illegalC", interruptCodeStatus_q, 16'(9 << 6));
			tick(8);
		end
		$display("Mapping test done");
		// Each async cause but illegal command and list end, with write-back on block ends
		for (int i = 0; i < 8; i++) begin
			words = '{16'($urandom), 16'($urandom), 16'($urandom)};
			{cbStatusWord, cbErrorWord, cbUnitWord} = {words[0], words[1], words[2]};
			cbFinish = i < 5;
			cbSoftErr = i == 0 || i == 2;
			cbHardErr = i == 1;
			cbSuspend = i == 2;
			cbIntOnDone = i == 3;
			interpStatusNz = i == 5;
			interpBadPage = i == 6;
			interpBadXfer = i == 7;
			tick();
			{cbFinish, interpStatusNz, interpBadPage, interpBadXfer} = 4'h0;
			chk("codeC", interruptCodeStatus_q, 16'(codes[i] << 6));
			tick();
			chk("asyncIrq", 16'(asyncIrq_q), 16'h0001);
			for (int k = 0; k < 3 && i < 5; k++) begin
				chk("wbValid", 16'(wbValid_q), 16'h0001);
				chk("wbWord", 16'(wbWord_q), 16'(k == 0 ? 11 : 13 + k));
				chk("wbData", wbData_q, words[k]);
				tick();
			end
			tick(12);
		end
		$display("Async code test done");
		// A block inside a list, from start to list end
		cbStart = 1'h1;
		listStart = 1'h1;
		tick();
		{cbStart, listStart} = 2'h0;
		chk("listOn", 16'(listStarted_q), 16'h0001);
		chk("doneClr", 16'(cmdComplete_q), 16'h0000);
		chk("busyOn", 16'(execBusy_q), 16'h0001);
		listDone = 1'h1;
		tick();
		listDone = 1'h0;
		chk("listOff", 16'(listStarted_q), 16'h0000);
		chk("doneSet", 16'(cmdComplete_q), 16'h0001);
		chk("busyOff", 16'(execBusy_q), 16'h0000);
		chk("listC", interruptCodeStatus_q, 16'(5 << 6));
		tick();
		chk("listIrq", 16'(asyncIrq_q), 16'h0001);
		tick(12);
		$display("List test done");
		// Async then sync, with sync disabled and enabled
		slow = 1'h1;
		for (int e = 0; e < 2; e++) begin
			pioReturnC = 16'($urandom);
			syncIntEnable = e[0];
			interpBadPage = 1'h1;
			tick();
			interpBadPage = 1'h0;
			pioDone = 1'h1;
			tick();
			pioDone = 1'h0;
			tick();
			chk("syncIrq", 16'(syncIrq_q), 16'(e));
			chk("asyncIrq", 16'(asyncIrq_q), 16'(1 - e));
			chk("syncC", interruptCodeStatus_q, e ? pioReturnC : 16'(11 << 6));
			tick(11);
			if (e) chk("asyncAfter", 16'(asyncIrq_q), 16'h0001);
			tick(20);
		end
		$display("Sync test done");
		// Failing commands load the error word
		slow = 1'h0;
		for (int r = 0; r < 8; r++) begin
			// Even rounds always fail a capable command
			{pioFail, pioErrCapable, pioErrEndAddr, pioErrChannel} =
				4'($urandom) | (r[0] ? 4'h0 : 4'hc);
			pioDone = 1'h1;
			if (pioFail && pioErrCapable)
				expB = {3'h0, pioErrChannel, 4'h0, pioErrEndAddr, 7'h00};
			tick();
			pioDone = 1'h0;
			chk("regB", errorStatusWord_q, expB);
			tick(8);
		end
		$display("Error word test done");
		stop_test();
	end
endmodule
